/* File: logic/mode_select_cell.sv */
// one mode select bit for one resource management domain
// assumes: write strobe already decoded for this domain, synchronous to mclk
`timescale 1ns/1ps
`include "region_mode_params.svh"

module mode_select_cell (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic wr_bit,
   output logic mode_q
);

   logic mode_d;

   // ***********************************************************
   // next value
   // ***********************************************************
   always_comb begin
      mode_d = mode_q;
      if (wr_en) begin
         mode_d = wr_bit;
      end
   end

   // ***********************************************************
   // storage
   // ***********************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= `MODE_SEL_RESET;
      end else begin
         mode_q <= mode_d;
      end
   end

endmodule : mode_select_cell

/* File: logic/region_mode_control.sv */
// bank of 64-bit mode control registers, one per resource management domain
// assumes: software reaches each register by a domain-selected read/write port,
// all inputs synchronous to mclk, one access per cycle
`timescale 1ns/1ps
`include "region_mode_params.svh"

// Overview of operation
// - every control register is a 64-bit word on the access port.
// - mode select bit 2 is read-write, resets to one, selects total legacy mode.
// - a cleared select bit enables per-region monitoring and allocation interfaces.
// - one register per domain, each steering only its own domain.
// - mixing legacy monitoring with region allocation is unsupported, results undefined.
// - legacy interfaces give total bandwidth only, never per-region.
// - bits 63:3 and 1:0 read zero; software writes back what it read.
module region_mode_control
   import region_mode_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire domain_sel_t reg_domain_sel,
   input wire reg_word_t reg_wdata,
   output reg_word_t reg_rdata,
   output logic reg_rd_valid,
   output domain_vec_t total_mode,
   output domain_vec_t region_mode,
   input wire domain_vec_t legacy_req,
   input wire logic [`NUM_DOMAINS*8-1:0] legacy_region_id,
   output domain_vec_t legacy_grant,
   input wire domain_vec_t region_req,
   output domain_vec_t region_grant,
   output logic mode_mismatch,
   output domain_vec_t legacy_misuse
);

   // ***********************************************************
   // helpers
   // ***********************************************************
   // builds a read word from one select bit; reserved fields read zero
   function automatic reg_word_t pack_word(input logic sel_bit);
      reg_word_t w;
      w = '0;
      w[`MODE_SEL_BIT] = sel_bit;
      return w;
   endfunction : pack_word

   // true when not every domain holds the same mode
   function automatic logic modes_differ(input domain_vec_t m);
      return !((&m) || !(|m));
   endfunction : modes_differ

   // true when a stored select bit picks total legacy operation
   function automatic logic is_total(input logic sel_bit);
      return sel_bit == `MODE_TOTAL;
   endfunction : is_total

   // true when a stored select bit picks per-region operation
   function automatic logic is_region(input logic sel_bit);
      return sel_bit == `MODE_REGION;
   endfunction : is_region

   // ***********************************************************
   // per-domain mode registers
   // ***********************************************************
   domain_vec_t mode_bits;
   domain_vec_t cell_wr;

   // only bit 2 of the written word reaches storage, so reserved writes do nothing
   always_comb begin
      cell_wr = '0;
      if (reg_wr_en) begin
         cell_wr[reg_domain_sel] = 1'h1;
      end
   end

   for (genvar g = 0; g < `NUM_DOMAINS; g++) begin : g_domain
      mode_select_cell u_cell (
         .mclk(mclk),
         .rst_n(rst_n),
         .wr_en(cell_wr[g]),
         .wr_bit(reg_wdata[`MODE_SEL_BIT]),
         .mode_q(mode_bits[g])
      );
   end

   // ***********************************************************
   // read path
   // ***********************************************************
   reg_word_t rdata_q;
   reg_word_t rdata_d;
   logic rd_valid_q;
   logic rd_valid_d;

   always_comb begin
      rdata_d = rdata_q;
      rd_valid_d = reg_rd_en;
      if (reg_rd_en) begin
         rdata_d = pack_word(mode_bits[reg_domain_sel]);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
         rd_valid_q <= 1'h0;
      end else begin
         rdata_q <= rdata_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rd_valid = rd_valid_q;

   // ***********************************************************
   // mode outputs and interface gating
   // ***********************************************************
   // the registered copies lag storage by one cycle so every output leaves a flop
   domain_vec_t total_q;
   domain_vec_t total_d;
   domain_vec_t region_q;
   domain_vec_t region_d;

   always_comb begin
      total_d = '0;
      region_d = '0;
      for (int i = 0; i < `NUM_DOMAINS; i++) begin
         total_d[i] = is_total(mode_bits[i]);
         region_d[i] = is_region(mode_bits[i]);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         total_q <= '1;
         region_q <= '0;
      end else begin
         total_q <= total_d;
         region_q <= region_d;
      end
   end

   // ***********************************************************
   // interface grants
   // ***********************************************************
   // grants read the stored bit, not the lagging copy, so they line up with the mode outputs
   domain_vec_t legacy_grant_q;
   domain_vec_t legacy_grant_d;
   domain_vec_t region_grant_q;
   domain_vec_t region_grant_d;

   always_comb begin
      legacy_grant_d = '0;
      region_grant_d = '0;
      for (int i = 0; i < `NUM_DOMAINS; i++) begin
         // legacy path serves total bandwidth; the region id it carries is ignored
         legacy_grant_d[i] = legacy_req[i] && is_total(mode_bits[i]);
         region_grant_d[i] = region_req[i] && is_region(mode_bits[i]);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         legacy_grant_q <= '0;
         region_grant_q <= '0;
      end else begin
         legacy_grant_q <= legacy_grant_d;
         region_grant_q <= region_grant_d;
      end
   end

   // ***********************************************************
   // misuse indication
   // ***********************************************************
   domain_vec_t misuse_q;
   domain_vec_t misuse_d;

   always_comb begin
      misuse_d = '0;
      for (int i = 0; i < `NUM_DOMAINS; i++) begin
         // a legacy access in region mode is refused rather than mixed in
         misuse_d[i] = legacy_req[i] && is_region(mode_bits[i]);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         misuse_q <= '0;
      end else begin
         misuse_q <= misuse_d;
      end
   end

   // ***********************************************************
   // cross-domain agreement
   // ***********************************************************
   // only flagged, never enforced: region grants keep flowing on a mismatch
   logic mismatch_q;
   logic mismatch_d;

   always_comb begin
      mismatch_d = modes_differ(mode_bits);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mismatch_q <= 1'h0;
      end else begin
         mismatch_q <= mismatch_d;
      end
   end

   // region id on the legacy path is deliberately unused: total mode has no regions
   logic unused_region_id;
   assign unused_region_id = ^legacy_region_id;

   assign total_mode = total_q;
   assign region_mode = region_q;
   assign legacy_grant = legacy_grant_q;
   assign region_grant = region_grant_q;
   assign legacy_misuse = misuse_q;
   assign mode_mismatch = mismatch_q;

endmodule : region_mode_control

/* File: logic/region_mode_params.svh */
// constants for the per-domain region mode control registers
// assumes: included by the package and by every design file that needs offsets or resets
`ifndef REGION_MODE_PARAMS_SVH
`define REGION_MODE_PARAMS_SVH

// ***********************************************************
// register geometry
// ***********************************************************
`define REG_WORD_WIDTH 64
`define MODE_SEL_BIT 2
`define MODE_SEL_RESET 1'h1

// ***********************************************************
// domain count (not fixed by the register map; plain default)
// ***********************************************************
`define NUM_DOMAINS 4
`define DOMAIN_SEL_WIDTH 2

// ***********************************************************
// mode encodings of the select bit
// ***********************************************************
`define MODE_TOTAL 1'h1
`define MODE_REGION 1'h0

`endif

/* File: logic/region_mode_pkg.sv */
// types shared by the region mode control block
// assumes: region_mode_params.svh is on the include path
`include "region_mode_params.svh"

package region_mode_pkg;
   typedef logic [`REG_WORD_WIDTH-1:0] reg_word_t;
   typedef logic [`DOMAIN_SEL_WIDTH-1:0] domain_sel_t;
   typedef logic [`NUM_DOMAINS-1:0] domain_vec_t;
endpackage : region_mode_pkg

/* File: tb/region_mode_chk.sv */
// concurrent checks on the region mode control bank
// assumes: bound to region_mode_control, single mclk domain
`timescale 1ns/1ps
module region_mode_chk
   import region_mode_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire domain_sel_t reg_domain_sel,
   input wire reg_word_t reg_wdata,
   input wire reg_word_t reg_rdata,
   input wire logic reg_rd_valid,
   input wire domain_vec_t total_mode,
   input wire domain_vec_t region_mode,
   input wire domain_vec_t legacy_req,
   input wire domain_vec_t legacy_grant,
   input wire domain_vec_t region_req,
   input wire domain_vec_t region_grant,
   input wire logic mode_mismatch,
   input wire domain_vec_t legacy_misuse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_rd_answer: assert property (reg_rd_en |=> reg_rd_valid &&
      reg_rdata == {61'h0, total_mode[$past(reg_domain_sel)], 2'h0}) else $error("read answer wrong");
   chk_rd_quiet: assert property (!reg_rd_en |=> !reg_rd_valid) else $error("stray read valid");
   chk_mode_inverse: assert property (region_mode == ~total_mode) else $error("modes not inverse");
   chk_write_store: assert property (reg_wr_en ##1 !reg_wr_en |=>
      total_mode[$past(reg_domain_sel, 2)] == $past(reg_wdata[2], 2)) else $error("write not stored");
   chk_legacy_grant: assert property ($past(rst_n) |->
      legacy_grant == ($past(legacy_req) & total_mode)) else $error("legacy grant wrong");
   chk_region_grant: assert property ($past(rst_n) |->
      region_grant == ($past(region_req) & region_mode)) else $error("region grant wrong");
   chk_legacy_misuse: assert property ($past(rst_n) |->
      legacy_misuse == ($past(legacy_req) & region_mode)) else $error("misuse flag wrong");
   chk_mode_agree: assert property (mode_mismatch ==
      (total_mode != 4'h0 && total_mode != 4'hf)) else $error("mismatch flag wrong");
   cover property (reg_wr_en && !reg_wdata[2]);
   cover property (|legacy_misuse);
   cover property (mode_mismatch);
endmodule : region_mode_chk

bind region_mode_control region_mode_chk chk_u (.mclk(mclk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
   .reg_rd_en(reg_rd_en), .reg_domain_sel(reg_domain_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rd_valid(reg_rd_valid), .total_mode(total_mode), .region_mode(region_mode), .legacy_req(legacy_req),
   .legacy_grant(legacy_grant), .region_req(region_req), .region_grant(region_grant),
   .mode_mismatch(mode_mismatch), .legacy_misuse(legacy_misuse));

/* File: tb/testbench.sv */
// directed bench for region_mode_control
// assumes: checker bound from its own file, 100 MHz mclk
`timescale 1ns/1ps
`include "region_mode_params.svh"
module testbench;
   import region_mode_pkg::*;
   logic mclk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, reg_rd_valid, mode_mismatch;
   domain_sel_t reg_domain_sel = '0;
   reg_word_t reg_wdata = '0, reg_rdata, rd_word;
   domain_vec_t legacy_req = '0, region_req = '0, total_mode, region_mode, legacy_grant, region_grant, legacy_misuse;
   logic [`NUM_DOMAINS*8-1:0] legacy_region_id = 32'ha5c3_0f96;
   int errors = 0, n_checks = 0;
   region_mode_control dut_u (.mclk(mclk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_domain_sel(reg_domain_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .total_mode(total_mode), .region_mode(region_mode), .legacy_req(legacy_req),
      .legacy_region_id(legacy_region_id), .legacy_grant(legacy_grant), .region_req(region_req),
      .region_grant(region_grant), .mode_mismatch(mode_mismatch), .legacy_misuse(legacy_misuse));
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input reg_word_t got, input reg_word_t exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wr(input domain_sel_t d, input reg_word_t w);
      @(posedge mclk) #1;
      reg_wr_en = 1;
      reg_domain_sel = d;
      reg_wdata = w;
      @(posedge mclk) #1;
      reg_wr_en = 0;
   endtask : wr
   // answer is valid just after the taking edge; the loop only guards a hang
   task automatic rd(input domain_sel_t d);
      @(posedge mclk) #1;
      reg_rd_en = 1;
      reg_domain_sel = d;
      @(posedge mclk) #1;
      reg_rd_en = 0;
      chk(reg_rd_valid, 1'h1, "read answer not next cycle");
      for (int i = 0; i < 4 && reg_rd_valid !== 1'h1; i++) @(posedge mclk) #1;
      if (reg_rd_valid !== 1'h1) begin
         errors++;
         $display("[FAIL] %0t read never answered", $time);
         end_of_test();
      end
      rd_word = reg_rdata;
   endtask : rd
   task automatic t_defaults();
      chk(total_mode, 4'hf, "total after reset");
      chk(region_mode, 4'h0, "region after reset");
      for (int d = 0; d < 4; d++) begin
         rd(d[1:0]);
         chk(rd_word, 64'h0000_0000_0000_0004, "reset word");
      end
      $display("done t_defaults");
   endtask : t_defaults
   // all reserved bits written as ones must not stick
   task automatic t_clear_one();
      wr(2'h1, 64'hffff_ffff_ffff_fffb);
      rd(2'h1);
      chk(rd_word, 64'h0000_0000_0000_0000, "cleared word");
      rd(2'h0);
      chk(rd_word, 64'h0000_0000_0000_0004, "other domain");
      chk(total_mode, 4'hd, "total one cleared");
      chk(region_mode, 4'h2, "region one set");
      chk(mode_mismatch, 1'h1, "mismatch seen");
      $display("done t_clear_one");
   endtask : t_clear_one
   task automatic t_grants();
      for (int d = 0; d < 4; d++) wr(d[1:0], 64'h0000_0000_0000_0000);
      legacy_req = 4'hf;
      region_req = 4'hf;
      repeat (2) @(posedge mclk) #1;
      chk(region_grant, 4'hf, "region grants");
      chk(legacy_grant, 4'h0, "no legacy grants");
      chk(legacy_misuse, 4'hf, "misuse flagged");
      chk(mode_mismatch, 1'h0, "all agree");
      wr(2'h2, 64'h0000_0000_0000_0004);
      @(posedge mclk) #1;
      chk(legacy_grant, 4'h4, "legacy grant");
      chk(region_grant, 4'hb, "region kept");
      chk(legacy_misuse, 4'hb, "misuse rest");
      legacy_req = 4'h0;
      region_req = 4'h0;
      $display("done t_grants");
   endtask : t_grants
   task automatic t_rerst();
      @(posedge mclk) #1;
      rst_n = 0;
      #1 chk(total_mode, 4'hf, "async reset");
      repeat (2) @(posedge mclk) #1;
      rst_n = 1;
      t_defaults();
      $display("done t_rerst");
   endtask : t_rerst
   initial begin
      repeat (2) @(posedge mclk) #1;
      rst_n = 1;
      t_defaults();
      t_clear_one();
      t_grants();
      t_rerst();
      end_of_test();
   end
endmodule : testbench
